// *** src/event_counter_free_run.sv ***
// event counter channel, free-run capable, with an axi4-lite register slave
// Functional notes
// - op_mode_sel 01 selects event counting
// - pulse_out_sel 0: output pin is plain port
// - edge_polarity_sel 0 counts falling input edges
// - dir_source_sel 0 takes direction from dir_flag
// - free_run_sel 1 selects free-running operation in event mode only
// - count_type_bit1 ignored, any value accepted
// - dir_flag 0 makes counter count down
// - trigger_source_sel 00 uses input pin edges
// - irq_priority three bits, 011 means level 3
// - run_flag 1 starts, 0 stops counting
// - request bit sticks until software writes 0
// - interrupt delivered on vector number 21
// - timer mode counts undivided peripheral clock
// - free-run wrap sets request, no reload
// - direction change applies at next edge
// - source: pin, group-b, either neighbour overflow
module event_counter_free_run
  import evcnt_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             count_in_pin,
  input  wire logic             dir_in_pin,
  input  wire logic             grpb_wrap,
  input  wire logic             prev_wrap,
  input  wire logic             next_wrap,
  output logic                  channel_out_pin,
  output logic                  channel_out_oe,
  output logic                  port_out_en,
  output logic                  wrap_pulse,
  output logic                  irq_request,
  output logic [2:0]            irq_level,
  output logic [7:0]            irq_vector
);

  mode_t             mode_reg;
  logic              dir_flag_reg;
  logic [1:0]        trig_reg;
  logic              run_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  reload_reg;
  irqc_t             irqc_reg;
  logic              port_data_reg;

  // axi write side: address and data latched independently
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = aw_held && w_held && !s_axi_bvalid;
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == MODE_OFS) || (a == DIR_OFS) || (a == TRIG_OFS) ||
                (a == RUN_OFS) || (a == CNT_OFS) || (a == IRQC_OFS) ||
                (a == VEC_OFS);
  endfunction : known_ofs

  wire wr_mode = wr_fire && (aw_addr == MODE_OFS) && w_strb[0];
  wire wr_dir  = wr_fire && (aw_addr == DIR_OFS)  && w_strb[0];
  wire wr_trig = wr_fire && (aw_addr == TRIG_OFS) && w_strb[0];
  wire wr_run  = wr_fire && (aw_addr == RUN_OFS)  && w_strb[0];
  wire wr_cnt  = wr_fire && (aw_addr == CNT_OFS);
  wire wr_irqc = wr_fire && (aw_addr == IRQC_OFS) && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take;
      s_axi_wready  <= !w_held && !w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_ofs(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // input synchronisers; first stage read only by second
  logic [1:0] cin_sync;
  logic [1:0] din_sync;
  logic       cin_last;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cin_sync <= 2'b11;
      din_sync <= 2'b00;
      cin_last <= 1'b1;
    end else begin
      cin_sync <= {cin_sync[0], count_in_pin};
      din_sync <= {din_sync[0], dir_in_pin};
      cin_last <= cin_sync[1];
    end
  end

  // pin edge: falling when polarity 0, rising otherwise
  wire pin_fall = cin_last && !cin_sync[1];
  wire pin_rise = !cin_last && cin_sync[1];
  wire pin_edge = mode_reg.edge_polarity_sel ? pin_rise : pin_fall;

  logic src_edge;
  always_comb begin
    case (trig_reg)
      TRIG_PIN:  src_edge = pin_edge;
      TRIG_GRPB: src_edge = grpb_wrap;
      TRIG_PREV: src_edge = prev_wrap;
      TRIG_NEXT: src_edge = next_wrap;
      default:   src_edge = 1'b0;
    endcase
  end

  wire event_mode = (mode_reg.op_mode_sel == OP_EVENT);
  wire timer_mode = (mode_reg.op_mode_sel == OP_TIMER);
  // timer mode counts every clock, down only
  wire tick = run_reg && (event_mode ? src_edge : timer_mode);
  // direction sampled at the edge itself, so a change lands on the next
  wire count_up = event_mode &&
    (mode_reg.dir_source_sel ? din_sync[1] : dir_flag_reg);
  wire at_top   = (cnt_reg == {CNT_W{1'b1}});
  wire at_zero  = (cnt_reg == '0);
  wire wrap_evt = tick && (count_up ? at_top : at_zero);
  wire reload_now = wrap_evt && !(event_mode && mode_reg.free_run_sel);

  logic [CNT_W-1:0] cnt_next;
  always_comb begin
    if (wr_cnt && !run_reg) begin
      cnt_next = w_data[CNT_W-1:0];
    end else if (reload_now) begin
      cnt_next = reload_reg;
    end else if (tick) begin
      cnt_next = count_up ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg      <= MODE_RST;
      dir_flag_reg  <= 1'b0;
      trig_reg      <= TRIG_PIN;
      run_reg       <= 1'b0;
      cnt_reg       <= CNT_RST;
      reload_reg    <= CNT_RST;
      irqc_reg      <= '{irq_request_bit: 1'b0, irq_priority: PRIO_RST};
      port_data_reg <= 1'b0;
    end else begin
      // count_type_bit1 is stored but steers nothing
      if (wr_mode) mode_reg <= mode_t'(w_data[7:0]);
      if (wr_dir)  dir_flag_reg <= w_data[0];
      if (wr_trig) trig_reg <= w_data[1:0];
      if (wr_run)  run_reg <= w_data[0];
      if (wr_run)  port_data_reg <= w_data[8];
      if (wr_cnt)  reload_reg <= w_data[CNT_W-1:0];
      cnt_reg <= cnt_next;
      if (wr_irqc) irqc_reg.irq_priority <= w_data[2:0];
      // a wrap in the clearing cycle wins over the clear
      if (wrap_evt) begin
        irqc_reg.irq_request_bit <= 1'b1;
      end else if (wr_irqc && !w_data[IRQ_REQ_BIT]) begin
        irqc_reg.irq_request_bit <= 1'b0;
      end
    end
  end

  // pin toggles per wrap when pulse output is on in event mode; else plain port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_out_pin <= 1'b0;
      channel_out_oe  <= 1'b0;
      port_out_en     <= 1'b1;
      wrap_pulse      <= 1'b0;
      irq_request     <= 1'b0;
      irq_level       <= PRIO_RST;
      irq_vector      <= IRQ_VECTOR;
    end else begin
      if (mode_reg.pulse_out_sel && event_mode) begin
        channel_out_oe <= !mode_reg.dir_source_sel;
        if (wrap_evt) channel_out_pin <= !channel_out_pin;
        port_out_en <= 1'b0;
      end else begin
        channel_out_pin <= port_data_reg;
        channel_out_oe  <= 1'b1;
        port_out_en     <= 1'b1;
      end
      wrap_pulse  <= wrap_evt;
      irq_request <= irqc_reg.irq_request_bit;
      irq_level   <= irqc_reg.irq_priority;
      irq_vector  <= IRQ_VECTOR;
    end
  end

  // read side: one cycle after arvalid, held until rready
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      MODE_OFS: rd_mux = {24'h000000, mode_reg};
      DIR_OFS:  rd_mux = {31'h0, dir_flag_reg};
      TRIG_OFS: rd_mux = {30'h0, trig_reg};
      RUN_OFS:  rd_mux = {23'h0, port_data_reg, 7'h00, run_reg};
      CNT_OFS:  rd_mux = {{(32-CNT_W){1'b0}}, cnt_reg};
      IRQC_OFS: rd_mux = {28'h0000000, irqc_reg};
      VEC_OFS:  rd_mux = {24'h000000, IRQ_VECTOR};
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= known_ofs(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  a_wrap_sets_req: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap_evt |=> irqc_reg.irq_request_bit)
    else $error("wrap lost");
  a_free_no_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap_evt && event_mode && mode_reg.free_run_sel && !wr_cnt && count_up
    |=> cnt_reg == '0) else $error("free-run reloaded");
  a_req_sticks: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irqc_reg.irq_request_bit && !wr_irqc |=> irqc_reg.irq_request_bit)
    else $error("request dropped");
  a_stop_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !run_reg && !wr_cnt |=> $stable(cnt_reg))
    else $error("counts stopped");
  a_down_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && event_mode && mode_reg.free_run_sel &&
    !mode_reg.dir_source_sel && !dir_flag_reg && !wr_cnt
    |=> cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("down count wrong");
  a_up_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tick && event_mode && mode_reg.free_run_sel &&
    !mode_reg.dir_source_sel && dir_flag_reg && !wr_cnt
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("up count wrong");
  a_pin_fall_cnt: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_reg && event_mode && trig_reg == TRIG_PIN && !wr_cnt &&
    !mode_reg.edge_polarity_sel && !pin_fall |=> $stable(cnt_reg))
    else $error("count without edge");
  a_pin_source: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_reg && event_mode && trig_reg == TRIG_PIN && !wr_cnt &&
    !pin_edge |=> $stable(cnt_reg))
    else $error("count from other source");
  a_one_count: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pin_fall |=> !pin_fall)
    else $error("edge counted twice");
  a_timer_tick: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run_reg && timer_mode && !at_zero
    |=> cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("timer tick wrong");
  a_port_mode: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !mode_reg.pulse_out_sel |=> port_out_en)
    else $error("pulse on");
  a_port_oe: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !mode_reg.pulse_out_sel
    |=> channel_out_oe && channel_out_pin == $past(port_data_reg))
    else $error("port pin wrong");
  a_wrap_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap_evt |=> wrap_pulse)
    else $error("wrap pulse missing");
  a_level_copy: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> irq_level == $past(irqc_reg.irq_priority))
    else $error("level wrong");
  a_vector_fixed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 irq_vector == 8'h15)
    else $error("vector wrong");
  a_irq_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irqc_reg.irq_request_bit |=> irq_request)
    else $error("irq out");
  a_rd_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

endmodule : event_counter_free_run

// *** src/evcnt_pkg.sv ***
// package: register map, field positions and constants for the event counter
package evcnt_pkg;

  // register byte offsets (chosen, aligned words)
  localparam logic [7:0] MODE_OFS  = 8'h00;
  localparam logic [7:0] DIR_OFS   = 8'h04;
  localparam logic [7:0] TRIG_OFS  = 8'h08;
  localparam logic [7:0] RUN_OFS   = 8'h0C;
  localparam logic [7:0] CNT_OFS   = 8'h10;
  localparam logic [7:0] IRQC_OFS  = 8'h14;
  localparam logic [7:0] VEC_OFS   = 8'h18;

  // mode register field positions
  localparam int OP_MODE_LSB      = 0;
  localparam int PULSE_OUT_BIT    = 2;
  localparam int EDGE_POL_BIT     = 3;
  localparam int DIR_SRC_BIT      = 4;
  localparam int MODE_BIT3_BIT    = 5;
  localparam int FREE_RUN_BIT     = 6;
  localparam int COUNT_TYPE1_BIT  = 7;

  // irq control register field positions
  localparam int IRQ_PRIO_LSB     = 0;
  localparam int IRQ_REQ_BIT      = 3;

  localparam logic [1:0] OP_TIMER   = 2'h0;
  localparam logic [1:0] OP_EVENT   = 2'h1;
  localparam logic [1:0] TRIG_PIN   = 2'h0;
  localparam logic [1:0] TRIG_GRPB  = 2'h1;
  localparam logic [1:0] TRIG_PREV  = 2'h2;
  localparam logic [1:0] TRIG_NEXT  = 2'h3;

  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [2:0]  PRIO_RST  = 3'h0;
  localparam logic [7:0]  IRQ_VECTOR = 8'h15;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       count_type_bit1;
    logic       free_run_sel;
    logic       mode_bit3_zero;
    logic       dir_source_sel;
    logic       edge_polarity_sel;
    logic       pulse_out_sel;
    logic [1:0] op_mode_sel;
  } mode_t;

  typedef struct packed {
    logic       irq_request_bit;
    logic [2:0] irq_priority;
  } irqc_t;

endpackage : evcnt_pkg

// *** tb/pulse_src.sv ***
// external pulse source driving the count input pin, idle high
module pulse_src;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk;
  logic count_in_pin = 1'b1;
  // gap sets low and high widths in clocks, so fast and slow trains both occur
  task automatic send(input int n, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge aclk);
      count_in_pin <= 1'b0;
      repeat (gap) @(posedge aclk);
      count_in_pin <= 1'b1;
    end
  endtask : send
endmodule : pulse_src

// *** tb/tb_top.sv ***
// self-checking bench for the free-run event counter channel
module tb_top;
  import evcnt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  // response readies stay high, so back-to-back calls never retoggle them
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic dir_in_pin = 0, grpb = 0, prev = 0, next = 0;
  logic out_pin, out_oe, port_out_en, wrap_pulse, irq_request;
  logic [2:0] irq_level;
  logic [7:0] irq_vector;
  logic [31:0] d;
  logic [15:0] v;
  int err_count = 0, checks = 0, n, up, wraps = 0;
  always #10 aclk = ~aclk;
  always @(posedge aclk) if (wrap_pulse === 1'b1) wraps++;
  pulse_src u_pulse_src();
  assign u_pulse_src.aclk = aclk;
  event_counter_free_run u_event_counter_free_run (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .count_in_pin(u_pulse_src.count_in_pin), .dir_in_pin(dir_in_pin),
    .grpb_wrap(grpb), .prev_wrap(prev), .next_wrap(next),
    .channel_out_pin(out_pin), .channel_out_oe(out_oe),
    .port_out_en(port_out_en), .wrap_pulse(wrap_pulse),
    .irq_request(irq_request), .irq_level(irq_level),
    .irq_vector(irq_vector));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= dv;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bit a_done;
    a_done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready && !a_done) begin
        a_done = 1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask : rd
  function automatic logic [15:0] step(logic [15:0] s, int k, int u);
    return u ? s + 16'(k) : s - 16'(k);
  endfunction : step
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (15000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hCB7AA1EF));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(VEC_OFS); chk(d, 32'h15);
    chk(irq_vector, 8'h15);
    chk(port_out_en, 1'b1);
    chk(out_oe, 1'b1);
    rd(8'h40); chk(r, RESP_SLVERR);
    chk(d, 0);
    // bit 7 random: the second count-type bit must not matter
    v = 16'h41 | 16'($urandom_range(1, 0) << 7);
    wr(MODE_OFS, v); rd(MODE_OFS); chk(d, v);
    chk(port_out_en, 1'b1);
    wr(DIR_OFS, 0);
    wr(TRIG_OFS, 0);
    wr(CNT_OFS, 3);
    wr(IRQC_OFS, 3);
    dir_in_pin <= 1'b1; // ignored while direction comes from the flag
    @(posedge aclk); chk(irq_level, 3'h3);
    wr(RUN_OFS, 32'h101);
    @(posedge aclk); chk(out_pin, 1'b1);
    u_pulse_src.send(4, 3);
    repeat (8) @(posedge aclk);
    rd(CNT_OFS); chk(d, 32'hFFFF);
    chk(irq_request, 1'b1);
    chk(wraps, 1);
    rd(IRQC_OFS); chk(d[3:0], 4'hB);
    grpb <= 1'b1;
    @(posedge aclk) grpb <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(CNT_OFS); chk(d, 32'hFFFF);
    chk(irq_request, 1'b1);
    wr(IRQC_OFS, 3);
    repeat (3) @(posedge aclk); chk(irq_request, 1'b0);
    wr(RUN_OFS, 0);
    u_pulse_src.send(2, 4);
    repeat (8) @(posedge aclk);
    rd(CNT_OFS); chk(d, 32'hFFFF);
    chk(out_pin, 1'b0);
    wr(CNT_OFS, 32'hFFFE);
    wr(DIR_OFS, 1);
    wr(RUN_OFS, 1);
    u_pulse_src.send(2, 5);
    repeat (8) @(posedge aclk);
    rd(CNT_OFS); chk(d, 0);
    chk(irq_request, 1'b1);
    chk(wraps, 2);
    for (int t = 1; t < 4; t++) begin
      wr(TRIG_OFS, t);
      grpb <= (t == 1);
      prev <= (t == 2);
      next <= (t == 3);
      @(posedge aclk);
      {grpb, prev, next} <= 3'b000;
      repeat (6) @(posedge aclk);
      rd(CNT_OFS); chk(d, t);
    end
    wr(TRIG_OFS, 0);
    v = 16'h3;
    repeat (6) begin
      up = $urandom_range(1, 0);
      n = $urandom_range(8, 1);
      wr(DIR_OFS, up);
      u_pulse_src.send(n, $urandom_range(6, 3));
      repeat (8) @(posedge aclk);
      v = step(v, n, up);
      rd(CNT_OFS); chk(d, v);
    end
    wr(RUN_OFS, 0);
    wr(IRQC_OFS, 0);
    wr(MODE_OFS, 0);
    wr(CNT_OFS, 5);
    wr(RUN_OFS, 1);
    // timer mode counts every clock, so underflow is near at hand
    n = 0;
    while (irq_request !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(irq_request, 1'b1);
    wrap_up();
  end
endmodule : tb_top
